//--- verilog/fsc_pkg.sv
package fsc_pkg;

	// Avalon register offsets (byte addresses)
	localparam logic [3:0] OFF_CTRL_LO  = 4'h0;  // Control word bits 31:0
	localparam logic [3:0] OFF_CTRL_HI  = 4'h4;  // Control word bits 63:32
	localparam logic [3:0] OFF_IRQ_STAT = 4'h8;  // Sticky event status
	localparam logic [3:0] OFF_IRQ_MASK = 4'hC;  // Event mask

	// Control word field positions
	localparam int TRAP_LSB   = 0;   // Trap-disable bits 5:0
	localparam int SET0_LSB   = 6;   // Main status set 18:6
	localparam int SET_W      = 13;  // Width of one status set
	localparam int RSV_LSB    = 58;  // Reserved 63:58
	localparam int RSV_W      = 6;

	// Status set field positions
	localparam int SF_FTZ     = 0;
	localparam int SF_WRE     = 1;
	localparam int SF_PC_LSB  = 2;
	localparam int SF_RC_LSB  = 4;
	localparam int SF_TD      = 6;
	localparam int SF_FLG_LSB = 7;

	// Exception order: invalid, denorm, zero divide, overflow, underflow, inexact
	localparam int EXC_INV = 0;
	localparam int EXC_DEN = 1;
	localparam int EXC_ZDV = 2;
	localparam int EXC_OVF = 3;
	localparam int EXC_UNF = 4;
	localparam int EXC_INX = 5;

	// Reset values
	localparam logic [63:0] CTRL_RST = 64'h0000_0000_0000_0000;
	localparam logic [1:0]  MASK_RST = 2'h0;

	// Rounding direction codes
	localparam logic [1:0] RC_NEAR = 2'h0;
	localparam logic [1:0] RC_DOWN = 2'h1;
	localparam logic [1:0] RC_UP   = 2'h2;
	localparam logic [1:0] RC_ZERO = 2'h3;

	// Dynamic precision codes
	localparam logic [1:0] PC_24  = 2'h0;
	localparam logic [1:0] PC_RSV = 2'h1;
	localparam logic [1:0] PC_53  = 2'h2;
	localparam logic [1:0] PC_64  = 2'h3;

	// Significand and exponent widths handed to the datapath
	localparam logic [6:0] SIG_24 = 7'h18;
	localparam logic [6:0] SIG_53 = 7'h35;
	localparam logic [6:0] SIG_64 = 7'h40;
	localparam logic [4:0] EXP_8  = 5'h08;
	localparam logic [4:0] EXP_11 = 5'h0B;
	localparam logic [4:0] EXP_15 = 5'h0F;
	localparam logic [4:0] EXP_17 = 5'h11;

	// Instruction precision classes
	typedef enum logic [1:0] {
		FSC_PS_NONE   = 2'h0,  // No suffix, uses dynamic fields
		FSC_PS_SINGLE = 2'h1,  // Single suffix
		FSC_PS_DOUBLE = 2'h2   // Double suffix
	} fsc_psfx_t;

	// Instruction issued by the datapath
	typedef struct packed {
		logic       valid;     // Instruction issues this cycle
		logic [1:0] set_sel;   // Status set suffix
		fsc_psfx_t  psfx;      // Static precision suffix
		logic       parallel;  // Paired-single instruction
		logic       nonarith;  // Non-parallel, no precision completer
	} fsc_issue_t;

	// Exception report from the datapath
	typedef struct packed {
		logic       valid;      // Instruction completes this cycle
		logic [1:0] set_sel;    // Status set it named
		logic [5:0] exc;        // Raised conditions
		logic       den_calc;   // Unnormal really entered the calculation
		logic       tiny;       // Result was tiny
	} fsc_done_t;

	// Controls applied to the datapath
	typedef struct packed {
		logic [1:0] round_direction;
		logic [6:0] sig_bits;
		logic [4:0] exp_bits;
		logic       flush_zero;
		logic       prec_rsv;
		logic [5:0] trap_off;
	} fsc_ctl_t;

	// Event summary of one completion
	typedef enum logic [1:0] {
		FSC_EV_FAULT = 2'h1,
		FSC_EV_FLAGS = 2'h2
	} fsc_ev_t;

endpackage : fsc_pkg

//--- verilog/fsc_unit.sv
// Function
// - 64-bit word: traps, four sets, reserved top
// - Trap-disable bits 0-5 suppress six exceptions
// - Set controls: ftz, wre, precision, rounding, td
// - Sticky flags at set bits 7 through 12
// - Main set td bit reads zero
// - Set td forces all traps disabled
// - Denormal flag only on real calculation use
// - Faults only from executing instructions
// - Flush-to-zero only while underflow disabled
// - Enabled underflow overrides flush-to-zero
// - Flush sets underflow and inexact flags
// - Rounding field selects four directions
// - Static suffix forces 24/53 bits, 8/11/17 exponent
// - Dynamic precision 24/53/64, 15/17 exponent
// - Paired-single uses 24-bit, 8-bit exponent
// - Non-arith without suffix uses 64/17
// - Named status set controls and records
`timescale 1ns/100ps
`default_nettype none

module fsc_unit
	import fsc_pkg::*;
(
	// Clock and reset
	input  wire logic        core_clk,
	input  wire logic        rst,
	// Avalon-MM slave
	input  wire logic [3:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	input  wire logic [3:0]  avs_byteenable,
	output logic      [31:0] avs_readdata,
	output logic             avs_waitrequest,
	// Datapath side
	input  wire fsc_issue_t  issue,
	input  wire fsc_done_t   done,
	output fsc_ctl_t         ctl,
	output logic             fault,
	output logic             flush_zero_res,
	// Interrupt
	output logic             irq
);

	// Architectural word and interrupt registers
	logic [63:0] fp_status_control_reg;  // Control word
	logic [1:0]  irq_stat_reg;           // Sticky events
	logic [1:0]  irq_mask_reg;           // Event mask
	logic        ack_reg;                // Bus answer phase

	// Extract a status set
	function automatic logic [12:0] set_of(input logic [63:0] w, input logic [1:0] s);
		set_of = w[SET0_LSB + SET_W*s +: SET_W];
	endfunction : set_of

	// Effective trap disables for a set
	function automatic logic [5:0] trap_off_of(input logic [63:0] w, input logic [1:0] s);
		logic [12:0] sf;
		sf = set_of(w, s);
		if (s != 2'h0 && sf[SF_TD])
			trap_off_of = 6'h3F;
		else
			trap_off_of = w[TRAP_LSB +: 6];
	endfunction : trap_off_of

	// Readback view with reserved bits zeroed
	function automatic logic [63:0] view_of(input logic [63:0] w);
		logic [63:0] v;
		v = w;
		v[RSV_LSB +: RSV_W] = '0;
		v[SET0_LSB + SF_TD] = 1'b0;
		view_of = v;
	endfunction : view_of

	// Completion decode
	logic [12:0] done_sf;      // Named set at completion
	logic [5:0]  done_off;     // Effective disables
	logic [5:0]  done_flags;   // Flags to OR in
	logic        done_flush;   // Result flushed
	logic        done_fault;   // Enabled exception

	// Decode one completion
	always_comb begin
		done_sf    = set_of(fp_status_control_reg, done.set_sel);
		done_off   = trap_off_of(fp_status_control_reg, done.set_sel);
		done_flags = done.exc;
		// denorm only when used in calculation
		done_flags[EXC_DEN] = done.exc[EXC_DEN] & done.den_calc;
		done_flush = done.tiny & done_sf[SF_FTZ] & done_off[EXC_UNF];
		if (done.tiny && !done_flush)
			done_flags[EXC_UNF] = 1'b1;
		if (done_flush) begin
			done_flags[EXC_UNF] = 1'b1;
			done_flags[EXC_INX] = 1'b1;
		end
		done_fault = done.valid & |(done_flags & ~done_off);
	end

	// Bus decode
	logic        bus_wr;   // Write accepted
	logic [31:0] be_mask;  // Byte mask
	logic [63:0] wr_word;  // Word after bus write
	logic [63:0] fl_word;  // Flag OR pattern

	always_comb begin
		bus_wr  = avs_write & ack_reg;
		be_mask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
		           {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
		wr_word = fp_status_control_reg;
		if (bus_wr && avs_address == OFF_CTRL_LO)
			wr_word[31:0] = (wr_word[31:0] & ~be_mask) | (avs_writedata & be_mask);
		if (bus_wr && avs_address == OFF_CTRL_HI)
			wr_word[63:32] = (wr_word[63:32] & ~be_mask) | (avs_writedata & be_mask);
		fl_word = '0;
		// flags go to the named set
		if (done.valid)
			fl_word[SET0_LSB + SET_W*done.set_sel + SF_FLG_LSB +: 6] = done_flags;
	end

	// Control word update
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			fp_status_control_reg <= CTRL_RST;
		end else begin
			// flags OR in, set beats clear
			fp_status_control_reg <= view_of(wr_word | fl_word);
		end
	end

	// Issue-side controls
	fsc_ctl_t    ctl_next;  // Controls for next cycle
	logic [12:0] iss_sf;    // Named set at issue

	always_comb begin
		iss_sf = set_of(fp_status_control_reg, issue.set_sel);
		ctl_next = '0;
		ctl_next.round_direction = iss_sf[SF_RC_LSB +: 2];
		// Effective disables first, flush gate reads them
		ctl_next.trap_off = trap_off_of(fp_status_control_reg, issue.set_sel);
		ctl_next.flush_zero = iss_sf[SF_FTZ] & ctl_next.trap_off[EXC_UNF];
		if (issue.parallel) begin
			ctl_next.sig_bits = SIG_24;
			ctl_next.exp_bits = EXP_8;
		end else if (issue.nonarith) begin
			ctl_next.sig_bits = SIG_64;
			ctl_next.exp_bits = EXP_17;
		end else begin
			case (issue.psfx)
				FSC_PS_SINGLE: begin
					ctl_next.sig_bits = SIG_24;
					ctl_next.exp_bits = iss_sf[SF_WRE] ? EXP_17 : EXP_8;
				end
				FSC_PS_DOUBLE: begin
					ctl_next.sig_bits = SIG_53;
					ctl_next.exp_bits = iss_sf[SF_WRE] ? EXP_17 : EXP_11;
				end
				default: begin
					ctl_next.exp_bits = iss_sf[SF_WRE] ? EXP_17 : EXP_15;
					case (iss_sf[SF_PC_LSB +: 2])
						PC_24:   ctl_next.sig_bits = SIG_24;
						PC_53:   ctl_next.sig_bits = SIG_53;
						PC_64:   ctl_next.sig_bits = SIG_64;
						default: ctl_next.prec_rsv = 1'b1;
					endcase
				end
			endcase
		end
	end

	// Registered controls and completion outputs
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			ctl            <= '0;
			fault          <= 1'b0;
			flush_zero_res <= 1'b0;
		end else begin
			ctl            <= ctl_next;
			fault          <= done_fault;
			flush_zero_res <= done.valid & done_flush;
		end
	end

	// Interrupt status and mask
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			irq_stat_reg <= MASK_RST;
			irq_mask_reg <= MASK_RST;
			irq          <= 1'b0;
		end else begin
			if (bus_wr && avs_address == OFF_IRQ_STAT)
				irq_stat_reg <= (irq_stat_reg & ~avs_writedata[1:0]) |
					{done.valid & |done_flags, done_fault};
			else
				irq_stat_reg <= irq_stat_reg | {done.valid & |done_flags, done_fault};
			if (bus_wr && avs_address == OFF_IRQ_MASK)
				irq_mask_reg <= avs_writedata[1:0];
			irq <= |(irq_stat_reg & irq_mask_reg);
		end
	end

	// Avalon answer: one wait cycle, then data
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			ack_reg         <= 1'b0;
			avs_waitrequest <= 1'b1;
			avs_readdata    <= '0;
		end else begin
			ack_reg         <= (avs_read | avs_write) & ~ack_reg;
			avs_waitrequest <= ~((avs_read | avs_write) & ~ack_reg);
			case (avs_address)
				OFF_CTRL_LO:  avs_readdata <= fp_status_control_reg[31:0];
				OFF_CTRL_HI:  avs_readdata <= fp_status_control_reg[63:32];
				OFF_IRQ_STAT: avs_readdata <= {30'h0, irq_stat_reg};
				OFF_IRQ_MASK: avs_readdata <= {30'h0, irq_mask_reg};
				default:      avs_readdata <= 32'h0000_0000;
			endcase
		end
	end

	// Checks

	// main td zero
	// Stored word never keeps the main set's td bit
	chk_main_td_zero: assert property (@(posedge core_clk) disable iff (rst)
		fp_status_control_reg[SET0_LSB + SF_TD] == 1'b0)
		else $error("main td set");

	// reserved zero
	// Top six bits never hold a one
	chk_rsv_zero: assert property (@(posedge core_clk) disable iff (rst)
		fp_status_control_reg[63:58] == 6'h00)
		else $error("reserved bits set");

	// flush flags
	// A flushed result leaves underflow set in its set
	chk_flush_flags: assert property (@(posedge core_clk) disable iff (rst)
		done.valid && done_flush |=> fp_status_control_reg[SET0_LSB +
		SET_W*$past(done.set_sel) + SF_FLG_LSB + EXC_UNF])
		else $error("flush flag lost");

	// fault needs completion
	// A fault pulse always follows a completing instruction
	chk_fault_cause: assert property (@(posedge core_clk) disable iff (rst)
		fault |-> $past(done.valid))
		else $error("fault without instruction");

	// flush requires disabled underflow
	// Flushed results only where underflow was off
	chk_flush_gate: assert property (@(posedge core_clk) disable iff (rst)
		flush_zero_res |-> $past(done_off[EXC_UNF]))
		else $error("flush with underflow on");

	// paired single widths
	// Paired instructions ignore both dynamic fields
	chk_pair_width: assert property (@(posedge core_clk) disable iff (rst)
		issue.parallel |=> ctl.sig_bits == SIG_24 && ctl.exp_bits == EXP_8)
		else $error("paired width wrong");

	// non-arith widths
	// Register file precision for completer-less ops
	chk_nonarith_w: assert property (@(posedge core_clk) disable iff (rst)
		!issue.parallel && issue.nonarith |=> ctl.sig_bits == SIG_64)
		else $error("non-arith width wrong");

	// td forces disables
	// Alternate set td masks every exception
	chk_td_force: assert property (@(posedge core_clk) disable iff (rst)
		issue.set_sel != 2'h0 && iss_sf[SF_TD] |=> ctl.trap_off == 6'h3F)
		else $error("td not applied");

	// rounding passes
	// Rounding field reaches the datapath unchanged
	chk_round_pass: assert property (@(posedge core_clk) disable iff (rst)
		issue.valid |=> ctl.round_direction == $past(iss_sf[SF_RC_LSB +: 2]))
		else $error("rounding direction wrong");

	// single suffix precision
	// Single suffix forces a 24-bit significand
	chk_single_sig: assert property (@(posedge core_clk) disable iff (rst)
		!issue.parallel && !issue.nonarith && issue.psfx == FSC_PS_SINGLE
		|=> ctl.sig_bits == SIG_24)
		else $error("single precision wrong");

	// double suffix precision
	// Double suffix forces a 53-bit significand
	chk_double_sig: assert property (@(posedge core_clk) disable iff (rst)
		!issue.parallel && !issue.nonarith && issue.psfx == FSC_PS_DOUBLE
		|=> ctl.sig_bits == SIG_53)
		else $error("double precision wrong");

	// single suffix range
	// Narrow range with wide range off
	chk_single_rng: assert property (@(posedge core_clk) disable iff (rst)
		!issue.parallel && !issue.nonarith && issue.psfx == FSC_PS_SINGLE &&
		!iss_sf[SF_WRE] |=> ctl.exp_bits == EXP_8)
		else $error("single range wrong");

	// dynamic narrow range
	// No suffix and wide range off gives 15 bits
	chk_dyn_range: assert property (@(posedge core_clk) disable iff (rst)
		!issue.parallel && !issue.nonarith && issue.psfx == FSC_PS_NONE &&
		!iss_sf[SF_WRE] |=> ctl.exp_bits == EXP_15)
		else $error("dynamic range wrong");

	// dynamic wide range
	// No suffix and wide range on gives 17 bits
	chk_dyn_wide: assert property (@(posedge core_clk) disable iff (rst)
		!issue.parallel && !issue.nonarith && issue.psfx == FSC_PS_NONE &&
		iss_sf[SF_WRE] |=> ctl.exp_bits == EXP_17)
		else $error("dynamic wide range wrong");

	// reserved precision
	// Reserved code is flagged to the datapath
	chk_rsv_prec: assert property (@(posedge core_clk) disable iff (rst)
		!issue.parallel && !issue.nonarith && issue.psfx == FSC_PS_NONE &&
		iss_sf[SF_PC_LSB +: 2] == PC_RSV |=> ctl.prec_rsv)
		else $error("reserved precision missed");

	// plain trap disables
	// Without td the six word bits govern
	chk_trap_plain: assert property (@(posedge core_clk) disable iff (rst)
		issue.set_sel == 2'h0 || !iss_sf[SF_TD]
		|=> ctl.trap_off == $past(fp_status_control_reg[TRAP_LSB +: 6]))
		else $error("trap disables wrong");

	// denormal gate
	// Unused unnormal operand never raises the flag
	chk_den_gate: assert property (@(posedge core_clk) disable iff (rst)
		done.valid && !done.den_calc |-> !done_flags[EXC_DEN])
		else $error("denormal flag without use");

	// live underflow
	// Enabled underflow never yields a flushed result
	chk_unf_live: assert property (@(posedge core_clk) disable iff (rst)
		done.valid && done.tiny && !done_off[EXC_UNF] |=> !flush_zero_res)
		else $error("flush with live underflow");

	// flags land
	// Every reported flag shows up in its named set
	chk_flag_or: assert property (@(posedge core_clk) disable iff (rst)
		done.valid |=> (fp_status_control_reg & $past(fl_word)) == $past(fl_word))
		else $error("flag not recorded");

	// flush control gate
	// Flush control only with underflow disabled
	chk_ftz_ctl: assert property (@(posedge core_clk) disable iff (rst)
		ctl.flush_zero |-> ctl.trap_off[EXC_UNF])
		else $error("flush control with underflow on");

	// Main scenarios seen
	cov_flush:    cover property (@(posedge core_clk) flush_zero_res);
	cov_fault:    cover property (@(posedge core_clk) fault);
	cov_irq:      cover property (@(posedge core_clk) irq);
	cov_prec_rsv: cover property (@(posedge core_clk) ctl.prec_rsv);
	cov_unf_live: cover property (@(posedge core_clk) done.valid && done.tiny && !done_flush);

endmodule : fsc_unit

`default_nettype wire

//--- tb/fsc_dp_model.sv
`timescale 1ns/100ps
`default_nettype none

// Datapath stand-in: issues instructions, reports completions
module fsc_dp_model
	import fsc_pkg::*;
(
	// Clock
	input  wire logic     core_clk,
	// Toward the unit
	output fsc_issue_t    issue,
	output fsc_done_t     done,
	// From the unit
	input  wire fsc_ctl_t ctl,
	input  wire logic     fault,
	input  wire logic     flush_zero_res
);

	// Quiet until asked
	initial begin
		issue = '0;
		done  = '0;
	end

	// Hold an issue, then take the controls applied to it
	task automatic run_issue(input fsc_issue_t i, output fsc_ctl_t c);
		@(posedge core_clk);
		issue <= i;
		repeat (2) @(posedge core_clk);
		issue <= '0;
		#1;
		c = ctl;
	endtask : run_issue

	// One-cycle completion, then catch the pulses it causes
	task automatic run_done(input fsc_done_t d, output logic f, output logic z);
		@(posedge core_clk);
		done <= d;
		@(posedge core_clk);
		done <= '0;
		#1;
		f = fault;
		z = flush_zero_res;
	endtask : run_done

endmodule : fsc_dp_model
`default_nettype wire

//--- tb/tb_fp_status_control_unit.sv
`timescale 1ns/100ps
`default_nettype none

module tb_fp_status_control_unit;
	import fsc_pkg::*;

	// Bus, datapath and bench state
	logic        core_clk;
	logic        rst;
	logic [3:0]  avs_address;
	logic        avs_read;
	logic        avs_write;
	logic [31:0] avs_writedata;
	logic [31:0] avs_readdata;
	logic        avs_waitrequest;
	fsc_issue_t  issue;
	fsc_done_t   done;
	fsc_ctl_t    ctl;
	logic        fault;
	logic        flush_zero_res;
	logic        irq;
	int          n_fail;
	int          compares;
	int          cycles;
	logic [31:0] q;
	fsc_ctl_t    c;
	logic        f;
	logic        z;

	// Unit under test, all byte lanes on
	fsc_unit uut (.core_clk(core_clk), .rst(rst), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(4'hF), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .issue(issue), .done(done), .ctl(ctl),
		.fault(fault), .flush_zero_res(flush_zero_res), .irq(irq));

	// Datapath partner
	fsc_dp_model dp (.core_clk(core_clk), .issue(issue), .done(done), .ctl(ctl),
		.fault(fault), .flush_zero_res(flush_zero_res));

	// Clock
	initial begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end

	// Verdict and end of run
	task end_of_test;
		$display("compares %0d n_fail %0d", compares, n_fail);
		if (n_fail == 0 && compares > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : end_of_test

	// Hang guard
	always @(posedge core_clk) begin
		cycles = cycles + 1;
		if (cycles == 4000) begin
			n_fail = n_fail + 1;
			end_of_test();
		end
	end

	// One comparison
	task chk(input logic [31:0] got, input logic [31:0] exp);
		compares = compares + 1;
		if (got !== exp) begin
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
			n_fail = n_fail + 1;
		end
	endtask : chk

	// One bus cycle, held until waitrequest is seen low
	task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
		@(posedge core_clk);
		avs_address   <= a;
		avs_write     <= w;
		avs_read      <= ~w;
		avs_writedata <= d;
		do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
		q = avs_readdata;
		avs_read  <= 1'b0;
		avs_write <= 1'b0;
	endtask : bus

	// Read and compare
	task rd(input logic [3:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0);
		chk(q, e);
	endtask : rd

	// Issue on set one and compare precision and range
	task ctl_case(input fsc_issue_t i, input logic [6:0] s, input logic [4:0] e);
		dp.run_issue(i, c);
		chk({20'h0, c.sig_bits, c.exp_bits}, {20'h0, s, e});
	endtask : ctl_case

	// Main sequence
	initial begin
		rst = 1'b1;
		avs_address = 4'h0;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_writedata = 32'h0;
		n_fail = 0;
		compares = 0;
		cycles = 0;
		repeat (20) @(posedge core_clk);
		rst <= 1'b0;
		rd(OFF_CTRL_LO, CTRL_RST[31:0]);
		bus(1'b1, OFF_CTRL_HI, 32'hFFFF_FFFF);
		rd(OFF_CTRL_HI, 32'h03FF_FFFF);
		bus(1'b1, OFF_CTRL_LO, 32'hFFFF_FFFF);
		rd(OFF_CTRL_LO, 32'hFFFF_EFFF);
		rd(4'h2, 32'h0);
		bus(1'b1, OFF_IRQ_MASK, 32'h1);
		bus(1'b1, OFF_CTRL_HI, 32'h0000_2041);
		// Set one: all traps off, precision 11, each rounding code
		for (int k = 0; k < 4; k++) begin
			bus(1'b1, OFF_CTRL_LO, 32'h0260_0000 | (32'(k) << 23));
			dp.run_issue('{1'b1, 2'h1, FSC_PS_NONE, 1'b0, 1'b0}, c);
			chk({24'h0, c.round_direction, c.trap_off}, {24'h0, 2'(k), 6'h3F});
		end
		ctl_case('{1'b1, 2'h1, FSC_PS_NONE, 1'b0, 1'b0}, SIG_64, EXP_15);
		ctl_case('{1'b1, 2'h1, FSC_PS_SINGLE, 1'b0, 1'b0}, SIG_24, EXP_8);
		ctl_case('{1'b1, 2'h1, FSC_PS_DOUBLE, 1'b0, 1'b0}, SIG_53, EXP_11);
		ctl_case('{1'b1, 2'h1, FSC_PS_NONE, 1'b1, 1'b0}, SIG_24, EXP_8);
		ctl_case('{1'b1, 2'h1, FSC_PS_NONE, 1'b0, 1'b1}, SIG_64, EXP_17);
		// Denormal seen but not used in the calculation
		dp.run_done('{1'b1, 2'h0, 6'h02, 1'b0, 1'b0}, f, z);
		chk({31'h0, f}, 32'h0);
		dp.run_done('{1'b1, 2'h0, 6'h04, 1'b0, 1'b0}, f, z);
		chk({31'h0, f}, 32'h1);
		rd(OFF_CTRL_LO, 32'h03E0_8000);
		repeat (2) @(posedge core_clk);
		chk({31'h0, irq}, 32'h1);
		bus(1'b1, OFF_IRQ_STAT, 32'h1);
		repeat (3) @(posedge core_clk);
		chk({31'h0, irq}, 32'h0);
		// Set two flushes; set three has underflow live
		dp.run_done('{1'b1, 2'h2, 6'h00, 1'b0, 1'b1}, f, z);
		chk({30'h0, f, z}, 32'h1);
		dp.run_done('{1'b1, 2'h3, 6'h00, 1'b0, 1'b1}, f, z);
		chk({30'h0, f, z}, 32'h2);
		rd(OFF_CTRL_HI, 32'h0100_3841);
		// Set two flush control, then reserved precision on set one
		dp.run_issue('{1'b1, 2'h2, FSC_PS_NONE, 1'b0, 1'b0}, c);
		chk({31'h0, c.flush_zero}, 32'h1);
		bus(1'b1, OFF_CTRL_LO, 32'h0220_0000);
		dp.run_issue('{1'b1, 2'h1, FSC_PS_NONE, 1'b0, 1'b0}, c);
		chk({24'h0, c.prec_rsv, c.sig_bits}, {24'h0, 1'b1, 7'h00});
		end_of_test();
	end

endmodule : tb_fp_status_control_unit
`default_nettype wire
